// *** phy_data_end.sv ***
// Transceiver end of the nibble / reduced di-bit data interface.
// Assumes a line front end on the same clock delivering decoded symbols.
//
// Overview of operation
// - Transmit clock from oscillator; sample on rising edge
// - MAC drives transmit signals on transmit clock
// - 100TX receive clock recovered; master clock if link down and autoneg off
// - 10T receive clock from line only during carrier
// - Receive outputs change on falling receive clock edge
// - MAC holds enable from preamble to last nibble
// - 100TX valid spans preamble through last data nibble
// - 10T drops preamble; valid starts at 5D
// - Error symbol raises error and sends 1110
// - Transmit error sends H symbols onto line
// - 100TX carrier sense follows J/K and T/R
// - Idle without T/R: drop carrier, one-cycle error
// - 10T carrier rises on preamble, falls on end
// - Half duplex collision when transmit and receive overlap
// - Reduced mode timed by reference clock, two-bit paths
// - Reduced mode upper transmit bits and error low
// - Carrier/valid rises at once on carrier detect
// - Carrier/valid falls on reference after last di-bit
// - Reduced receive di-bits, 00 until decoding starts
// - MAC ignores di-bits while carrier/valid low
// - MAC reduced enable spans preamble to final di-bit
// - Di-bits taken only while enable high; idle 00
// - MAC regenerates collision from enable and carrier/valid
`timescale 1ns/1ps
module phy_data_end
    import phy_mii_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    mii_link_if.phy link,
    input wire logic rmii_mode_in,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic link_up_in,
    input wire logic autoneg_en_in,
    input wire logic line_carrier_in,
    input wire logic line_rx_clk_tick_in,
    input wire logic line_rx_valid_in,
    input wire phy_mii_pkg::line_sym_t line_rx_sym_in,
    input wire logic [phy_mii_pkg::NIB_W-1:0] line_rx_nibble_in,
    output logic line_rx_ready_out,
    output logic line_tx_valid_out,
    output logic [phy_mii_pkg::NIB_W-1:0] line_tx_nibble_out,
    output logic line_tx_halt_out,
    output logic rx_clk_from_line_out
);
    import phy_mii_pkg::*;

    logic tx_clk_ff;
    logic rx_clk_ff;
    logic tx_valid_ff;
    logic [NIB_W-1:0] tx_nibble_ff;
    logic tx_halt_ff;
    logic [DIBIT_W-1:0] tx_lo_ff;
    logic tx_half_ff;
    rx_state_t rx_state_ff;
    logic crs_ff;
    logic idle_err_ff;
    logic pend_v_ff;
    logic [NIB_W:0] pend_ff;
    logic use_line_ff;
    logic rx_tick;
    logic rx_fall;
    logic tx_rise;
    logic take;
    logic wr_valid;
    logic [FIFO_W-1:0] wr_word;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic [FIFO_W-1:0] fifo_rd_word;
    logic fifo_pop;
    logic [NIB_W-1:0] rxd_ff;
    logic rx_valid_ff;
    logic rx_err_ff;
    logic [NIB_W-1:0] cur_ff;
    logic cur_v_ff;
    logic cur_last_ff;
    logic dib_hi_ff;
    logic dv_active_ff;
    logic is_end;

    // Transmit clock is the oscillator divided by two
    assign tx_rise = ~tx_clk_ff;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_clk_ff <= 1'b0;
        end else begin
            tx_clk_ff <= rmii_mode_in ? 1'b0 : ~tx_clk_ff;
        end
    end

    // Receive clock source: line recovery or master oscillator
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            use_line_ff <= 1'b0;
        end else if (speed_100_in) begin
            use_line_ff <= link_up_in | autoneg_en_in;
        end else begin
            use_line_ff <= crs_ff;
        end
    end
    assign rx_clk_from_line_out = use_line_ff;
    assign rx_tick = use_line_ff ? line_rx_clk_tick_in : 1'b1;
    assign rx_fall = rx_clk_ff & rx_tick;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_clk_ff <= 1'b0;
        end else if (rmii_mode_in) begin
            rx_clk_ff <= 1'b0;
        end else if (rx_tick) begin
            rx_clk_ff <= ~rx_clk_ff;
        end
    end

    // Transmit capture toward the line; one strobe per nibble
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_valid_ff <= 1'b0;
            tx_nibble_ff <= ZERO_NIBBLE;
            tx_halt_ff <= 1'b0;
            tx_lo_ff <= IDLE_DIBIT;
            tx_half_ff <= 1'b0;
        end else if (!rmii_mode_in) begin
            tx_valid_ff <= tx_rise & link.tx_nibble_enable;
            if (tx_rise) begin
                tx_nibble_ff <= link.txd;
                tx_halt_ff <= link.tx_nibble_enable & link.tx_nibble_error;
            end
        end else begin
            tx_valid_ff <= 1'b0;
            tx_halt_ff <= 1'b0;
            if (link.ref_tick) begin
                if (!link.tx_nibble_enable) begin
                    tx_half_ff <= 1'b0;
                end else if (!tx_half_ff) begin
                    tx_lo_ff <= link.txd[1:0];
                    tx_half_ff <= 1'b1;
                end else begin
                    tx_nibble_ff <= {link.txd[1:0], tx_lo_ff};
                    tx_valid_ff <= 1'b1;
                    tx_half_ff <= 1'b0;
                end
            end
        end
    end
    assign line_tx_valid_out = tx_valid_ff;
    assign line_tx_nibble_out = tx_nibble_ff;
    assign line_tx_halt_out = tx_halt_ff;

    // Symbol intake; one nibble of lookahead marks the frame's last nibble
    assign take = line_rx_valid_in & fifo_wr_ready;
    assign line_rx_ready_out = fifo_wr_ready;
    assign is_end = (line_rx_sym_in == SYM_TR) || (line_rx_sym_in == SYM_IDLE);
    always_comb begin
        wr_valid = 1'b0;
        wr_word = {pend_ff[NIB_W], 1'b0, pend_ff[NIB_W-1:0]};
        if (take && pend_v_ff) begin
            unique case (rx_state_ff)
                RX_PASS: begin
                    wr_valid = 1'b1;
                    wr_word[FW_LAST] = is_end;
                end
                RX_HUNT: begin
                    wr_valid = (pend_ff[NIB_W-1:0] == SFD_LO) && (line_rx_nibble_in == SFD_HI);
                end
                RX_IDLE: begin
                    wr_valid = 1'b0;
                end
                default: begin
                    wr_valid = 1'b0;
                end
            endcase
        end
    end

    // Receive frame state, carrier sense and lookahead nibble
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_state_ff <= RX_IDLE;
            crs_ff <= 1'b0;
            pend_v_ff <= 1'b0;
            pend_ff <= '0;
        end else if (take) begin
            if (rx_state_ff == RX_IDLE) begin
                pend_v_ff <= 1'b0;
                if (speed_100_in && line_rx_sym_in == SYM_JK) begin
                    crs_ff <= 1'b1;
                    rx_state_ff <= RX_PASS;
                end else if (!speed_100_in && line_rx_sym_in == SYM_DATA &&
                             line_rx_nibble_in == PRE_NIBBLE) begin
                    crs_ff <= 1'b1;
                    rx_state_ff <= RX_HUNT;
                    pend_v_ff <= 1'b1;
                    pend_ff <= {1'b0, line_rx_nibble_in};
                end
            end else if (is_end) begin
                crs_ff <= 1'b0;
                rx_state_ff <= RX_IDLE;
                pend_v_ff <= 1'b0;
            end else begin
                if (wr_valid) begin
                    rx_state_ff <= RX_PASS;
                end
                pend_v_ff <= 1'b1;
                if (line_rx_sym_in == SYM_ERR) begin
                    pend_ff <= {1'b1, ERR_NIBBLE};
                end else begin
                    pend_ff <= {1'b0, line_rx_nibble_in};
                end
            end
        end
    end

    // Idle without T/R: error flag held until the next receive update
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            idle_err_ff <= 1'b0;
        end else if (take && speed_100_in && rx_state_ff == RX_PASS &&
                     line_rx_sym_in == SYM_IDLE) begin
            idle_err_ff <= 1'b1;
        end else if (rx_fall || (rmii_mode_in && link.ref_tick)) begin
            idle_err_ff <= 1'b0;
        end
    end

    stream_fifo #(
        .WIDTH(FIFO_W),
        .DEPTH(FIFO_DEPTH)
    ) rx_fifo (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .in_valid_in(wr_valid),
        .in_data_in(wr_word),
        .in_ready_out(fifo_wr_ready),
        .out_valid_out(fifo_rd_valid),
        .out_data_out(fifo_rd_word),
        .out_ready_in(fifo_pop)
    );

    // Drain: one nibble per receive clock, or two di-bits per word
    assign fifo_pop = rmii_mode_in ? (link.ref_tick && !(cur_v_ff && !dib_hi_ff))
                                   : rx_fall;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rxd_ff <= ZERO_NIBBLE;
            rx_valid_ff <= 1'b0;
            rx_err_ff <= 1'b0;
            cur_ff <= ZERO_NIBBLE;
            cur_v_ff <= 1'b0;
            cur_last_ff <= 1'b0;
            dib_hi_ff <= 1'b0;
            dv_active_ff <= 1'b0;
        end else if (!rmii_mode_in) begin
            if (rx_fall) begin
                rx_valid_ff <= fifo_rd_valid;
                rxd_ff <= fifo_rd_valid ? fifo_rd_word[NIB_W-1:0] : ZERO_NIBBLE;
                rx_err_ff <= (fifo_rd_valid & fifo_rd_word[FW_ERR]) | idle_err_ff;
            end
        end else if (link.ref_tick) begin
            rx_valid_ff <= 1'b0;
            if (cur_v_ff && !dib_hi_ff) begin
                rxd_ff <= {2'h0, cur_ff[3:2]};
                dib_hi_ff <= 1'b1;
                if (cur_last_ff) begin
                    cur_v_ff <= 1'b0;
                end
            end else if (fifo_rd_valid) begin
                cur_ff <= fifo_rd_word[NIB_W-1:0];
                cur_last_ff <= fifo_rd_word[FW_LAST];
                cur_v_ff <= 1'b1;
                dib_hi_ff <= 1'b0;
                dv_active_ff <= 1'b1;
                rxd_ff <= {2'h0, fifo_rd_word[1:0]};
                rx_err_ff <= fifo_rd_word[FW_ERR] | idle_err_ff;
            end else begin
                rxd_ff <= {2'h0, IDLE_DIBIT};
                cur_v_ff <= 1'b0;
                dv_active_ff <= 1'b0;
                rx_err_ff <= idle_err_ff;
            end
        end
    end

    // Link outputs; the unused interface stays quiet
    assign link.tx_nibble_clock = tx_clk_ff;
    assign link.rx_nibble_clock = rx_clk_ff;
    assign link.rxd = rxd_ff;
    assign link.rx_nibble_valid = rx_valid_ff;
    assign link.rx_nibble_error = rx_err_ff;
    assign link.crs = ~rmii_mode_in & crs_ff;
    // Collision is combinational on purpose: no clock may delay it
    assign link.col = ~rmii_mode_in & ~full_duplex_in & link.tx_nibble_enable & crs_ff;
    // Raw carrier detect raises this at once; fall waits for the last di-bit
    assign link.crs_dv = rmii_mode_in & (line_carrier_in | dv_active_ff);
endmodule : phy_data_end

// *** phy_mii_pkg.sv ***
// Constants and types shared by both ends of the nibble/di-bit data link.
// Assumes a single 25 MHz system clock and no software-visible registers.
package phy_mii_pkg;
    localparam int NIB_W = 4;
    localparam int DIBIT_W = 2;
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_W = 6;
    // Receive FIFO word layout: {err, last, nibble}
    localparam int FW_ERR = 5;
    localparam int FW_LAST = 4;
    localparam logic [3:0] ERR_NIBBLE = 4'hE;
    localparam logic [3:0] SFD_LO = 4'h5;
    localparam logic [3:0] SFD_HI = 4'hD;
    localparam logic [3:0] PRE_NIBBLE = 4'h5;
    localparam logic [3:0] ZERO_NIBBLE = 4'h0;
    localparam logic [1:0] IDLE_DIBIT = 2'h0;
    localparam logic [1:0] PRE_DIBIT = 2'h1;
    // Reference tick divider; stands in for the 50 MHz reference at this rate
    localparam int REF_DIV = 2;
    localparam logic [1:0] REF_LAST = 2'(REF_DIV - 1);
    typedef enum logic [2:0] {
        SYM_DATA = 3'h0,
        SYM_JK = 3'h1,
        SYM_TR = 3'h2,
        SYM_IDLE = 3'h3,
        SYM_ERR = 3'h4
    } line_sym_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'h0,
        RX_HUNT = 2'h1,
        RX_PASS = 2'h2
    } rx_state_t;
endpackage : phy_mii_pkg

// *** mii_link_if.sv ***
// Interface joining the transceiver end and the MAC end.
// Assumes both ends run on the same clk_in; link clocks are level signals.
`timescale 1ns/1ps
interface mii_link_if;
    logic tx_nibble_clock;
    logic tx_nibble_enable;
    logic tx_nibble_error;
    logic [3:0] txd;
    logic rx_nibble_clock;
    logic rx_nibble_valid;
    logic rx_nibble_error;
    logic [3:0] rxd;
    logic crs;
    logic col;
    logic ref_tick;
    logic crs_dv;
    modport phy (
        output tx_nibble_clock, rx_nibble_clock, rx_nibble_valid, rx_nibble_error,
        output rxd, crs, col, crs_dv,
        input tx_nibble_enable, tx_nibble_error, txd, ref_tick
    );
    modport mac (
        input tx_nibble_clock, rx_nibble_clock, rx_nibble_valid, rx_nibble_error,
        input rxd, crs, col, crs_dv,
        output tx_nibble_enable, tx_nibble_error, txd, ref_tick
    );
endinterface : mii_link_if

// *** stream_fifo.sv ***
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; in_ready_out low when full, out_valid_out low when empty.
`timescale 1ns/1ps
module stream_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 32
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic in_valid_in,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic in_ready_out,
    output logic out_valid_out,
    output logic [WIDTH-1:0] out_data_out,
    input wire logic out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] count_ff;
    logic push;
    logic pop;

    // Honest flags from the occupancy count
    assign in_ready_out = (count_ff != (AW+1)'(DEPTH));
    assign out_valid_out = (count_ff != '0);
    assign out_data_out = mem[rd_ptr_ff];
    assign push = in_valid_in & in_ready_out;
    assign pop = out_valid_out & out_ready_in;

    // Storage written without reset; only pointers and count need a defined value
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data_in;
        end
    end

    // Pointers and count
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule : stream_fifo

// *** mac_data_end.sv ***
// MAC end of the nibble / reduced di-bit data interface.
// Assumes the transceiver end shares clk_in; user streams are valid/ready.
`timescale 1ns/1ps
module mac_data_end
    import phy_mii_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_b_in,
    mii_link_if.mac link,
    input wire logic rmii_mode_in,
    input wire logic tx_valid_in,
    input wire logic [phy_mii_pkg::NIB_W-1:0] tx_nibble_in,
    input wire logic tx_error_in,
    output logic tx_ready_out,
    output logic rx_valid_out,
    output logic [phy_mii_pkg::NIB_W-1:0] rx_nibble_out,
    output logic rx_error_out,
    output logic rx_end_out,
    output logic crs_out,
    output logic col_out
);
    import phy_mii_pkg::*;

    logic [1:0] ref_cnt_ff;
    logic ref_tick_ff;
    logic tx_en_ff;
    logic tx_er_ff;
    logic [NIB_W-1:0] txd_ff;
    logic [NIB_W-1:0] hold_ff;
    logic hold_hi_ff;
    logic rx_clk_prev_ff;
    logic rx_sync_ff;
    logic rx_half_ff;
    logic [DIBIT_W-1:0] rx_lo_ff;
    logic in_frame_ff;
    logic rx_valid_ff;
    logic [NIB_W-1:0] rx_nibble_ff;
    logic rx_error_ff;
    logic rx_end_ff;
    logic tx_fall;
    logic rx_rise;
    logic hi_due;

    // Reference tick divider
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ref_cnt_ff <= 2'h0;
            ref_tick_ff <= 1'b0;
        end else begin
            ref_tick_ff <= (ref_cnt_ff == REF_LAST);
            ref_cnt_ff <= (ref_cnt_ff == REF_LAST) ? 2'h0 : ref_cnt_ff + 2'h1;
        end
    end

    // Transmit changes on the falling transmit clock, stable at rising
    assign tx_fall = link.tx_nibble_clock;
    assign hi_due = ~hold_hi_ff & tx_en_ff;
    assign tx_ready_out = rmii_mode_in ? (ref_tick_ff & ~hi_due) : tx_fall;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_en_ff <= 1'b0;
            tx_er_ff <= 1'b0;
            txd_ff <= ZERO_NIBBLE;
            hold_ff <= ZERO_NIBBLE;
            hold_hi_ff <= 1'b1;
        end else if (!rmii_mode_in) begin
            if (tx_fall) begin
                tx_en_ff <= tx_valid_in;
                tx_er_ff <= tx_valid_in & tx_error_in;
                txd_ff <= tx_valid_in ? tx_nibble_in : ZERO_NIBBLE;
            end
        end else if (ref_tick_ff) begin
            tx_er_ff <= 1'b0;
            if (hi_due) begin
                txd_ff <= {2'h0, hold_ff[3:2]};
                hold_hi_ff <= 1'b1;
            end else if (tx_valid_in) begin
                hold_ff <= tx_nibble_in;
                hold_hi_ff <= 1'b0;
                tx_en_ff <= 1'b1;
                txd_ff <= {2'h0, tx_nibble_in[1:0]};
            end else begin
                tx_en_ff <= 1'b0;
                txd_ff <= {2'h0, IDLE_DIBIT};
            end
        end
    end

    // Receive sampling at the rising receive clock or the reference tick
    assign rx_rise = link.rx_nibble_clock & ~rx_clk_prev_ff;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rx_clk_prev_ff <= 1'b0;
            rx_sync_ff <= 1'b0;
            rx_half_ff <= 1'b0;
            rx_lo_ff <= IDLE_DIBIT;
            in_frame_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_nibble_ff <= ZERO_NIBBLE;
            rx_error_ff <= 1'b0;
            rx_end_ff <= 1'b0;
        end else begin
            rx_clk_prev_ff <= link.rx_nibble_clock;
            rx_valid_ff <= 1'b0;
            rx_end_ff <= 1'b0;
            if (!rmii_mode_in && rx_rise) begin
                rx_valid_ff <= link.rx_nibble_valid;
                rx_nibble_ff <= link.rxd;
                rx_error_ff <= link.rx_nibble_error;
                in_frame_ff <= link.rx_nibble_valid;
                rx_end_ff <= in_frame_ff & ~link.rx_nibble_valid;
            end else if (rmii_mode_in && ref_tick_ff) begin
                in_frame_ff <= link.crs_dv;
                rx_end_ff <= in_frame_ff & ~link.crs_dv;
                if (!link.crs_dv) begin
                    rx_sync_ff <= 1'b0;
                    rx_half_ff <= 1'b0;
                end else if (!rx_sync_ff) begin
                    if (link.rxd[1:0] == PRE_DIBIT) begin
                        rx_sync_ff <= 1'b1;
                        rx_half_ff <= 1'b1;
                        rx_lo_ff <= PRE_DIBIT;
                    end
                end else if (!rx_half_ff) begin
                    rx_lo_ff <= link.rxd[1:0];
                    rx_half_ff <= 1'b1;
                end else begin
                    rx_nibble_ff <= {link.rxd[1:0], rx_lo_ff};
                    rx_valid_ff <= 1'b1;
                    rx_error_ff <= link.rx_nibble_error;
                    rx_half_ff <= 1'b0;
                end
            end
        end
    end
    assign rx_valid_out = rx_valid_ff;
    assign rx_nibble_out = rx_nibble_ff;
    assign rx_error_out = rx_error_ff;
    assign rx_end_out = rx_end_ff;

    // Collision regenerated locally in reduced mode
    assign crs_out = rmii_mode_in ? link.crs_dv : link.crs;
    assign col_out = rmii_mode_in ? (tx_en_ff & link.crs_dv) : link.col;

    assign link.ref_tick = ref_tick_ff;
    assign link.tx_nibble_enable = tx_en_ff;
    assign link.tx_nibble_error = tx_er_ff;
    assign link.txd = txd_ff;
endmodule : mac_data_end

// *** mii_link_chk.sv ***
// Concurrent checks on the signals that join the two data-link ends.
// Assumes it sits beside mii_link_if in the bench, on the shared clk_in.
`timescale 1ns/1ps
module mii_link_chk (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic tx_nibble_clock,
    input wire logic tx_nibble_enable,
    input wire logic tx_nibble_error,
    input wire logic [3:0] txd,
    input wire logic rx_nibble_clock,
    input wire logic rx_nibble_valid,
    input wire logic [3:0] rxd,
    input wire logic crs,
    input wire logic col,
    input wire logic ref_tick,
    input wire logic crs_dv
);
    // One domain, so one clock and one reset for every property
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);

    // Transmit clock never stays high two cycles
    txclk_toggle_a: assert property (tx_nibble_clock |=> !tx_nibble_clock)
        else $error("transmit clock held high");
    // MAC launches data only on the edge where the clock drops
    txd_launch_a: assert property ($changed({txd, tx_nibble_enable}) |-> !tx_nibble_clock)
        else $error("transmit data changed off the clock fall");
    // Receive status moves only with a falling receive clock
    rx_fall_a: assert property ($changed(rx_nibble_valid) |-> $fell(rx_nibble_clock))
        else $error("receive valid moved without clock fall");
    // Collision needs both directions busy
    col_cause_a: assert property (col |-> tx_nibble_enable && crs)
        else $error("collision without overlap");
    // Reduced carrier never overlaps nibble outputs
    mode_excl_a: assert property (crs_dv |-> !crs && !rx_nibble_valid && !rx_nibble_clock)
        else $error("both interfaces active");
    // Di-bit receive keeps the upper pair quiet
    rmii_rxd_a: assert property (crs_dv |-> rxd[3:2] == 2'h0)
        else $error("upper receive bits set in reduced mode");
    // Reference tick stands for the half-rate reference edge
    ref_tick_a: assert property (ref_tick |=> !ref_tick ##1 ref_tick)
        else $error("reference tick spacing wrong");
    // A parked transmit clock means reduced mode: upper bits and error low
    rmii_tx_a: assert property ($stable(tx_nibble_clock) |-> txd[3:2] == 2'h0 && !tx_nibble_error)
        else $error("upper transmit bits or error set in reduced mode");

    // Main scenarios reached
    cover property (col);
    cover property ($fell(crs_dv));
    cover property (rx_nibble_valid && rxd == 4'hE);
endmodule : mii_link_chk

// *** test_phy_mii_rmii_data_interface.sv ***
// Self-checking bench joining the transceiver end and the MAC end.
// Assumes package, interface, FIFO, both ends and checker compile first.
`timescale 1ns/1ps
module test_phy_mii_rmii_data_interface;
    import phy_mii_pkg::*;
    logic clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic rmii_mode_in = 1'b0, speed_100_in = 1'b1, full_duplex_in = 1'b0, carrier = 1'b0;
    logic tick = 1'b0, lv = 1'b0, tv = 1'b0, te = 1'b0, col_seen = 1'b0, crs_seen = 1'b0;
    line_sym_t sym = SYM_DATA;
    logic [3:0] lnib = 4'h0, tn = 4'h0, ltn, rn;
    logic lrdy, ltv, lth, trdy, rv, re, rend, col_o, crs_o;
    logic [5:0] txq[$], rxq[$];
    logic [3:0] tx_nibs[5] = '{4'h5, 4'h5, 4'hD, 4'hA, 4'h3};
    logic [3:0] rx_nibs[6] = '{4'h5, 4'h5, 4'h5, 4'hD, 4'h7, 4'hE};
    int err_count = 0, comparisons = 0;

    mii_link_if link();
    phy_data_end phy_data_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
        .rmii_mode_in(rmii_mode_in), .speed_100_in(speed_100_in), .full_duplex_in(full_duplex_in),
        .link_up_in(1'b1), .autoneg_en_in(1'b0), .line_carrier_in(carrier),
        .line_rx_clk_tick_in(tick), .line_rx_valid_in(lv), .line_rx_sym_in(sym),
        .line_rx_nibble_in(lnib), .line_rx_ready_out(lrdy), .line_tx_valid_out(ltv),
        .line_tx_nibble_out(ltn), .line_tx_halt_out(lth), .rx_clk_from_line_out());
    mac_data_end mac_data_end_i (.clk_in(clk_in), .rst_b_in(rst_b_in), .link(link),
        .rmii_mode_in(rmii_mode_in), .tx_valid_in(tv), .tx_nibble_in(tn), .tx_error_in(te),
        .tx_ready_out(trdy), .rx_valid_out(rv), .rx_nibble_out(rn), .rx_error_out(re),
        .rx_end_out(rend), .crs_out(crs_o), .col_out(col_o));
    mii_link_chk mii_link_chk_i (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .tx_nibble_clock(link.tx_nibble_clock), .tx_nibble_enable(link.tx_nibble_enable),
        .tx_nibble_error(link.tx_nibble_error), .txd(link.txd),
        .rx_nibble_clock(link.rx_nibble_clock), .rx_nibble_valid(link.rx_nibble_valid),
        .rxd(link.rxd), .crs(link.crs), .col(link.col), .ref_tick(link.ref_tick),
        .crs_dv(link.crs_dv));

    always #20 clk_in = ~clk_in;

    // Recovered tick every other cycle; capture both streams as they leave
    always @(posedge clk_in) begin
        tick <= #1 ~tick;
        if (ltv) txq.push_back({1'b0, lth, ltn});
        if (rv) rxq.push_back({re, rend, rn});
        if (col_o) col_seen <= 1'b1;
        if (crs_o) crs_seen <= 1'b1;
        // Frame-end pulse trails the last nibble, so mark the entry already queued
        if (rend) rxq.push_back(rxq.pop_back() | 6'h10);
    end

    task automatic give_verdict();
        if (err_count == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [5:0] got, input logic [5:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Hold the nibble until the MAC takes it
    task automatic tx_nib(input logic [3:0] nib, input logic err);
        tv = 1'b1;
        tn = nib;
        te = err;
        while (!trdy) @(posedge clk_in) #1;
        @(posedge clk_in) #1;
    endtask : tx_nib

    // Hold the line symbol until the receive buffer has room
    task automatic rx_sym(input line_sym_t s, input logic [3:0] nib);
        lv = 1'b1;
        sym = s;
        lnib = nib;
        while (!lrdy) @(posedge clk_in) #1;
        @(posedge clk_in) #1;
    endtask : rx_sym

    // One frame each way at once, so half duplex sees a collision
    task automatic run(input logic rmii, input logic spd, input logic fd);
        rst_b_in = 1'b0;
        rmii_mode_in = rmii;
        speed_100_in = spd;
        full_duplex_in = fd;
        repeat (2) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        col_seen = 1'b0;
        crs_seen = 1'b0;
        txq.delete();
        rxq.delete();
        fork
            begin
                foreach (tx_nibs[i]) tx_nib(tx_nibs[i], i == 4);
                tv = 1'b0;
                te = 1'b0;
            end
            begin
                carrier = 1'b1;
                if (spd) rx_sym(SYM_JK, 4'h0);
                foreach (rx_nibs[i]) rx_sym(i == 5 ? SYM_ERR : SYM_DATA, rx_nibs[i]);
                rx_sym(SYM_TR, 4'h0);
                lv = 1'b0;
                carrier = 1'b0;
            end
        join
        for (int k = 0; k < 300 && rxq.size() < (spd ? 6 : 4); k++) @(posedge clk_in);
        // Room for the frame-end pulse; leave the edge before touching inputs
        repeat (12) @(posedge clk_in);
        #1;
        foreach (tx_nibs[i]) check(txq.pop_front(), {1'b0, (i == 4) & !rmii, tx_nibs[i]});
        for (int i = spd ? 0 : 2; i < 6; i++) check(rxq.pop_front(), {i == 5, i == 5, rx_nibs[i]});
        check(6'(txq.size() + rxq.size()), 6'h00);
        check({5'h00, col_seen}, {5'h00, rmii | !fd});
        check({5'h00, crs_seen}, 6'h01);
    endtask : run

    initial begin
        run(1'b0, 1'b1, 1'b0);
        run(1'b0, 1'b0, 1'b1);
        run(1'b1, 1'b1, 1'b0);
        run(1'b1, 1'b0, 1'b1);
        give_verdict();
    end

    // Hang guard, well beyond four runs of one frame each way
    initial begin
        #200000;
        err_count++;
        give_verdict();
    end
endmodule : test_phy_mii_rmii_data_interface
